// >>> logic/cgcs_pkg.sv
/*
 * Package for the CAN global control and status block: register addresses, control and status
 * bit positions, reset values, timing counts and the carrier structs.
 * Assumes an 8-bit special-function-register bus on the core clock.
 */
package cgcs_pkg;
	localparam logic [7:0] GEN_STATUS_ADDR = 8'hAA;
	localparam logic [7:0] GEN_CONTROL_ADDR = 8'hAB;
	localparam int CTL_ABORT = 7;
	localparam int CTL_OVERLOAD = 6;
	localparam int CTL_TTC = 5;
	localparam int CTL_SYNC_END = 4;
	localparam int CTL_LISTEN = 3;
	localparam int CTL_TEST = 2;
	localparam int CTL_ENABLE = 1;
	localparam int CTL_SOFT_RESET = 0;
	localparam int STA_OVERLOAD = 6;
	localparam int STA_TX_BUSY = 4;
	localparam int STA_RX_BUSY = 3;
	localparam int STA_ENABLED = 2;
	localparam int STA_BUS_OFF = 1;
	localparam int STA_ERR_PASSIVE = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int CLK_HZ = 40000000;
	localparam int START_DELAY_PERIODS = 2;
	localparam logic [1:0] START_DELAY_CYCLES = 2'(START_DELAY_PERIODS);
	localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
	localparam logic [8:0] BUS_OFF_LIMIT = 9'h0FF;
	localparam int TIMER_WIDTH = 16;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} cgcs_sfr_req_t;

	typedef struct packed {
		logic tx_frame;
		logic tx_ack;
		logic tx_pending;
		logic rx_frame;
		logic frame_idle;
		logic rx_msg_end;
		logic overload_start;
		logic overload_end;
		logic sof;
		logic eof_last;
		logic [7:0] tec;
		logic [7:0] rec;
		logic tec_bus_off;
	} cgcs_proto_t;

	typedef enum logic [1:0] {
		CGCS_STANDBY = 2'b00,
		CGCS_STARTING = 2'b01,
		CGCS_RUNNING = 2'b10,
		CGCS_STOPPING = 2'b11
	} cgcs_mode_t;
endpackage

// >>> logic/cgcs_sync2.sv
/*
 * Two-flop synchroniser for the pin-level receive line.
 * Assumes the input is asynchronous to clk.
 */
`timescale 1ns/1ps
module cgcs_sync2 (
	input wire logic clk,
	input wire logic rst,
	input wire logic d,
	output logic q
);
	logic meta_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= 1'b1;
			q <= 1'b1;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// >>> logic/cgcs_top.sv
/*
 * Global control and status of the CAN controller: control register, status register, enable
 * and standby sequencing, soft reset, abort, overload request, time-trigger capture and timer.
 * Assumes the protocol engine reports its frame events on proto, synchronous to clk, and that
 * the recessive CAN level is 1.
 */
`timescale 1ns/1ps
// Contract
// R01 - Abort clears all object enables and drops pending transmissions; ongoing frame completes.
// R02 - Abort bit stays set until software writes zero.
// R03 - Overload request sends one overload frame after next message; cleared when it starts.
// R04 - Bit 5 selects time-triggered operation; clear disables its features.
// R05 - In time-triggered mode capture timer at end-of-frame if bit 4, else start-of-frame.
// R06 - Bit 3 selects listen-only; clearing returns to normal.
// R07 - Software leaves test bit 2 cleared.
// R08 - Enable bit enables controller and ungates its clock.
// R09 - Clearing enable finishes current frame then freezes; object enables unchanged.
// R10 - Standby drives recessive transmit, receiver inactive, clock stopped.
// R11 - Registers stay accessible while disabled.
// R12 - Protocol engine starts two clock periods after enable is set.
// R13 - Soft reset bit resets like hardware reset, self-clears, leaves controller disabled.
// R14 - Status bit 6 high while own overload frame is sent.
// R15 - Status bit 4 high while transmitting or frame waits in interframe space.
// R16 - Status bit 3 high while receiver acquires or monitors a frame.
// R17 - Status bit 2 shows true enabled state once command takes effect.
// R18 - Status is read-only; bit 1 bus-off, bit 0 error-passive.
// R19 - Timer counts only once controller is enabled.
// R20 - Listen-only never acknowledges or transmits; error counters frozen.
// R21 - Time-triggered mode sends each frame once, no retransmission.
// R22 - Error-passive above 127 errors, bus-off above 255 transmit errors.
module cgcs_top #(
	parameter int NUM_OBJECTS = 15
) (
	input wire logic clk,
	input wire logic rst,
	input cgcs_pkg::cgcs_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	input cgcs_pkg::cgcs_proto_t proto,
	input wire logic [NUM_OBJECTS-1:0] object_enable_set,
	input wire logic tx_from_engine,
	input wire logic can_rx_pin,
	output logic can_tx_pin,
	output logic can_rx_to_engine,
	output logic engine_clk_en,
	output logic engine_run,
	output logic engine_reset,
	output logic listen_only,
	output logic no_retransmit,
	output logic overload_pending,
	output logic drop_pending_tx,
	output logic [NUM_OBJECTS-1:0] object_enable,
	output logic [cgcs_pkg::TIMER_WIDTH-1:0] timer_value,
	output logic [cgcs_pkg::TIMER_WIDTH-1:0] ttc_capture,
	output logic ttc_capture_valid
);
	import cgcs_pkg::*;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] status;
		cgcs_mode_t mode;
		logic [1:0] start_cnt;
		logic [7:0] rdata;
		logic tx;
		logic rx;
		logic clk_en;
		logic run;
		logic eng_rst;
		logic listen;
		logic no_retx;
		logic ovl_pend;
		logic drop;
		logic [NUM_OBJECTS-1:0] obj_en;
		logic [TIMER_WIDTH-1:0] timer;
		logic [TIMER_WIDTH-1:0] capture;
		logic cap_valid;
	} cgcs_state_t;

	cgcs_state_t state_reg;
	cgcs_state_t state_next;
	logic rx_sync;
	logic soft_reset_hit;

	cgcs_sync2 rx_sync_i (
		.clk(clk),
		.rst(rst),
		.d(can_rx_pin),
		.q(rx_sync)
	);

	function automatic logic reg_hit(input cgcs_sfr_req_t r, input logic [7:0] a);
		reg_hit = r.addr == a;
	endfunction

	assign soft_reset_hit = sfr_req.wr && reg_hit(sfr_req, GEN_CONTROL_ADDR) && sfr_req.wdata[CTL_SOFT_RESET];

	always_comb begin
		logic busy;
		logic tx_active;
		logic [8:0] tec9;
		logic [8:0] rec9;
		busy = 1'b0;
		tx_active = 1'b0;
		tec9 = 9'h000;
		rec9 = 9'h000;
		state_next = state_reg;
		state_next.eng_rst = 1'b0;
		state_next.drop = 1'b0;
		state_next.cap_valid = 1'b0;
		busy = proto.tx_frame || proto.rx_frame || proto.tx_ack;
		// The control register stays writable in every mode, including standby. [R11]
		if (sfr_req.wr && reg_hit(sfr_req, GEN_CONTROL_ADDR)) begin
			state_next.ctrl = sfr_req.wdata;
			state_next.ctrl[CTL_SOFT_RESET] = 1'b0; // [R13]
		end
		// The overload request is dropped once its frame goes out. [R03]
		if (proto.overload_start && state_reg.ctrl[CTL_OVERLOAD]) begin
			state_next.ctrl[CTL_OVERLOAD] = 1'b0;
		end
		// Abort stays set; it clears every object enable while held. [R01] [R02]
		if (state_reg.ctrl[CTL_ABORT]) begin
			state_next.obj_en = '0;
			state_next.drop = 1'b1;
		end else begin
			state_next.obj_en = state_reg.obj_en | object_enable_set;
		end
		case (state_reg.mode)
			CGCS_STANDBY: begin
				if (state_reg.ctrl[CTL_ENABLE]) begin
					state_next.mode = CGCS_STARTING;
					state_next.start_cnt = 2'd1;
					state_next.clk_en = 1'b1; // [R08]
				end
			end
			CGCS_STARTING: begin
				// The engine is released on the second period after enable. [R12]
				if (!state_reg.ctrl[CTL_ENABLE]) begin
					state_next.mode = CGCS_STANDBY;
					state_next.clk_en = 1'b0;
				end else if (state_reg.start_cnt == START_DELAY_CYCLES) begin
					state_next.mode = CGCS_RUNNING;
					state_next.run = 1'b1;
				end else begin
					state_next.start_cnt = state_reg.start_cnt + 2'd1;
				end
			end
			CGCS_RUNNING: begin
				if (!state_reg.ctrl[CTL_ENABLE]) begin
					state_next.mode = CGCS_STOPPING;
				end
			end
			CGCS_STOPPING: begin
				// The frame on the bus finishes before the engine freezes. [R09]
				if (state_reg.ctrl[CTL_ENABLE]) begin
					state_next.mode = CGCS_RUNNING;
				end else if (!busy) begin
					state_next.mode = CGCS_STANDBY;
					state_next.run = 1'b0;
					state_next.clk_en = 1'b0; // [R10]
				end
			end
			default: begin
				state_next.mode = CGCS_STANDBY;
			end
		endcase
		state_next.listen = state_reg.ctrl[CTL_LISTEN]; // [R06]
		state_next.no_retx = state_reg.ctrl[CTL_TTC]; // [R21] [R04]
		state_next.ovl_pend = state_next.ctrl[CTL_OVERLOAD];
		// Standby holds the line recessive and blinds the receiver; listen-only never drives. [R10] [R20]
		tx_active = state_reg.run && !state_reg.listen;
		state_next.tx = tx_active ? tx_from_engine : 1'b1;
		state_next.rx = state_reg.clk_en ? rx_sync : 1'b1;
		// Timer runs only while enabled. [R19]
		if (state_reg.run) begin
			state_next.timer = state_reg.timer + 16'h0001;
		end
		// Time-triggered capture point follows the sync bit. [R05] [R04]
		if (state_reg.ctrl[CTL_TTC] && state_reg.run) begin
			if (state_reg.ctrl[CTL_SYNC_END] ? proto.eof_last : proto.sof) begin
				state_next.capture = state_reg.timer;
				state_next.cap_valid = 1'b1;
			end
		end
		tec9 = {1'b0, proto.tec};
		rec9 = {1'b0, proto.rec};
		state_next.status = 8'h00;
		state_next.status[STA_OVERLOAD] = proto.overload_start || (state_reg.status[STA_OVERLOAD]
			&& !proto.overload_end); // [R14]
		state_next.status[STA_TX_BUSY] = proto.tx_frame || proto.tx_ack
			|| (proto.frame_idle && proto.tx_pending && !state_reg.ctrl[CTL_ABORT]); // [R15]
		state_next.status[STA_RX_BUSY] = proto.rx_frame; // [R16]
		state_next.status[STA_ENABLED] = state_next.run; // [R17]
		state_next.status[STA_BUS_OFF] = proto.tec_bus_off || tec9 > BUS_OFF_LIMIT; // [R22] [R18]
		state_next.status[STA_ERR_PASSIVE] = !state_next.status[STA_BUS_OFF]
			&& (tec9 > PASSIVE_LIMIT || rec9 > PASSIVE_LIMIT); // [R22] [R18]
		state_next.rdata = 8'h00;
		if (sfr_req.rd && reg_hit(sfr_req, GEN_STATUS_ADDR)) begin
			state_next.rdata = state_reg.status;
		end else if (sfr_req.rd && reg_hit(sfr_req, GEN_CONTROL_ADDR)) begin
			state_next.rdata = state_reg.ctrl;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.ctrl <= CONTROL_RESET;
			state_reg.status <= STATUS_RESET;
			state_reg.mode <= CGCS_STANDBY;
			state_reg.tx <= 1'b1;
			state_reg.rx <= 1'b1;
			state_reg.eng_rst <= 1'b1;
		end else if (soft_reset_hit) begin
			// Soft reset is ORed with the hardware reset and leaves the node disabled. [R13]
			state_reg <= '0;
			state_reg.ctrl <= CONTROL_RESET;
			state_reg.mode <= CGCS_STANDBY;
			state_reg.tx <= 1'b1;
			state_reg.rx <= 1'b1;
			state_reg.eng_rst <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sfr_rdata = state_reg.rdata;
	assign can_tx_pin = state_reg.tx;
	assign can_rx_to_engine = state_reg.rx;
	assign engine_clk_en = state_reg.clk_en;
	assign engine_run = state_reg.run;
	assign engine_reset = state_reg.eng_rst;
	assign listen_only = state_reg.listen;
	assign no_retransmit = state_reg.no_retx;
	assign overload_pending = state_reg.ovl_pend;
	assign drop_pending_tx = state_reg.drop;
	assign object_enable = state_reg.obj_en;
	assign timer_value = state_reg.timer;
	assign ttc_capture = state_reg.capture;
	assign ttc_capture_valid = state_reg.cap_valid;

	abort_sticky_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R02]
		state_reg.ctrl[CTL_ABORT] && !(sfr_req.wr && reg_hit(sfr_req, GEN_CONTROL_ADDR))
		|=> state_reg.ctrl[CTL_ABORT]) else $error("abort bit cleared by hardware");
	abort_clears_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R01]
		state_reg.ctrl[CTL_ABORT] |=> object_enable == '0) else $error("object enables survive abort");
	start_delay_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R12]
		state_reg.mode == CGCS_STANDBY && state_reg.ctrl[CTL_ENABLE] |=> !engine_run [*2] ##1 engine_run)
		else $error("engine start not two periods after enable");
	standby_tx_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R10]
		!engine_run |=> can_tx_pin) else $error("transmit not recessive in standby");
	listen_tx_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R20]
		listen_only |=> can_tx_pin) else $error("listen-only drove the bus");
	overload_clear_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R03]
		proto.overload_start && state_reg.ctrl[CTL_OVERLOAD] && !sfr_req.wr |=> !state_reg.ctrl[CTL_OVERLOAD])
		else $error("overload request not cleared");
	enable_flag_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R17]
		state_reg.status[STA_ENABLED] == (state_reg.mode == CGCS_RUNNING || state_reg.mode == CGCS_STOPPING))
		else $error("enable flag wrong");
	timer_hold_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R19]
		!engine_run |=> $stable(timer_value)) else $error("timer moved while disabled");
	stop_busy_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R09]
		state_reg.mode == CGCS_STOPPING && proto.tx_frame && !state_reg.ctrl[CTL_ENABLE] |=> engine_run)
		else $error("engine froze mid-frame");
	listen_mode_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R06]
		state_reg.ctrl[CTL_LISTEN]
		|=> listen_only) else $error("listen-only not entered");
	listen_exit_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R06]
		!state_reg.ctrl[CTL_LISTEN]
		|=> !listen_only) else $error("listen-only not left");
	ttc_mode_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R21]
		state_reg.ctrl[CTL_TTC]
		|=> no_retransmit) else $error("retransmission allowed in time-triggered mode");
	ttc_off_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R04]
		!state_reg.ctrl[CTL_TTC]
		|=> !no_retransmit && !ttc_capture_valid) else $error("time-triggered feature active while off");
	capture_end_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R05]
		state_reg.ctrl[CTL_TTC] && state_reg.ctrl[CTL_SYNC_END] && engine_run && proto.eof_last
		|=> ttc_capture_valid && ttc_capture == $past(timer_value)) else $error("no capture at frame end");
	capture_start_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R05]
		state_reg.ctrl[CTL_TTC] && !state_reg.ctrl[CTL_SYNC_END] && engine_run && proto.sof
		|=> ttc_capture_valid) else $error("no capture at frame start");
	clk_en_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R08]
		state_reg.mode == CGCS_STANDBY && state_reg.ctrl[CTL_ENABLE]
		|=> engine_clk_en) else $error("engine clock not ungated on enable");
	clk_gate_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R10]
		state_reg.mode == CGCS_STANDBY
		|-> !engine_clk_en) else $error("engine clock running in standby");
	rx_block_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R10]
		!engine_clk_en
		|=> can_rx_to_engine) else $error("receiver active in standby");
	overload_flag_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R14]
		proto.overload_start
		|=> state_reg.status[STA_OVERLOAD]) else $error("overload flag not set");
	tx_busy_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R15]
		proto.tx_frame || proto.tx_ack
		|=> state_reg.status[STA_TX_BUSY]) else $error("transmitter busy flag not set");
	rx_busy_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R16]
		proto.rx_frame
		|=> state_reg.status[STA_RX_BUSY]) else $error("receiver busy flag not set");
	bus_off_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R22]
		proto.tec_bus_off
		|=> state_reg.status[STA_BUS_OFF] && !state_reg.status[STA_ERR_PASSIVE]) else $error("bus-off flag wrong");
	passive_a: assert property (@(posedge clk) disable iff (rst || soft_reset_hit) // [R22]
		!proto.tec_bus_off && {1'b0, proto.tec} > PASSIVE_LIMIT
		|=> state_reg.status[STA_ERR_PASSIVE]) else $error("error-passive flag not set");
	soft_reset_a: assert property (@(posedge clk) disable iff (rst) // [R13]
		soft_reset_hit
		|=> state_reg.ctrl == CONTROL_RESET && !engine_run && engine_reset) else $error("soft reset incomplete");
endmodule

// >>> tb/cgcs_bus_node.sv
/*
 * Far CAN node seen through a line transceiver.
 * Assumes a wired-AND bus whose recessive level is 1.
 */
`timescale 1ns/1ps
module cgcs_bus_node (
	input wire logic clk,
	input wire logic node_drive,
	input wire logic dut_tx,
	output logic bus_rx
);
	// The bus is pulled recessive unless one party drives it dominant.
	always_ff @(posedge clk) begin
		bus_rx <= dut_tx & node_drive;
	end
endmodule

// >>> tb/tb.sv
/*
 * Self-checking testbench for the CAN global control and status block.
 * Assumes cgcs_pkg, the design files and cgcs_bus_node are compiled first.
 */
`timescale 1ns/1ps
module tb;
	import cgcs_pkg::*;
	localparam logic [7:0] ca = GEN_CONTROL_ADDR;
	localparam logic [7:0] sa = GEN_STATUS_ADDR;
	logic clk = 0;
	logic rst = 1;
	cgcs_sfr_req_t sfr_req = '0;
	cgcs_proto_t proto = '0;
	logic [14:0] oe_set = '0;
	logic tx_eng = 1;
	logic node_drive = 1;
	logic can_rx_pin, can_tx_pin, engine_run, clk_en, listen_only, no_retx, ovl_pend, drop_tx, cap_v;
	logic rx_eng, eng_rst;
	logic [15:0] cap_val;
	logic [7:0] rdata;
	logic [14:0] obj_en;
	logic [15:0] timer_value;
	int fails = 0, checks = 0, cyc = 0, ctl_m = 0, n, tec, rec, bo;
	integer seed = 32'h7E5FC7F7;
	always #12.5 clk = ~clk;
	cgcs_top u_dut (.clk(clk), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(rdata), .proto(proto),
		.object_enable_set(oe_set), .tx_from_engine(tx_eng), .can_rx_pin(can_rx_pin),
		.can_tx_pin(can_tx_pin), .can_rx_to_engine(rx_eng), .engine_clk_en(clk_en), .engine_run(engine_run),
		.engine_reset(eng_rst), .listen_only(listen_only), .no_retransmit(no_retx), .overload_pending(ovl_pend),
		.drop_pending_tx(drop_tx), .object_enable(obj_en), .timer_value(timer_value), .ttc_capture(cap_val),
		.ttc_capture_valid(cap_v));
	cgcs_bus_node u_node (.clk(clk), .node_drive(node_drive), .dut_tx(can_tx_pin), .bus_rx(can_rx_pin));
	task automatic report_and_stop;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		tx_eng <= 1'($random(seed));
		node_drive <= 1'($random(seed));
		if (cyc == 5000) begin
			fails++;
			report_and_stop;
		end
	end
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// The bench never sets the test mode bit.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		sfr_req.wr <= 1'b0;
		if (a == ca)
			ctl_m = d[0] ? 0 : d;
	endtask
	task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		sfr_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		sfr_req.rd <= 1'b0;
		#1 chk(name, exp, rdata);
	endtask
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic set_obj;
		@(posedge clk);
		oe_set <= '1;
		@(posedge clk);
		oe_set <= '0;
	endtask
	task automatic cap_cnt(input int which, input int exp);
		int c = 0;
		logic [15:0] t;
		@(posedge clk);
		if (which == 0)
			proto.sof <= 1'b1;
		else
			proto.eof_last <= 1'b1;
		#1 t = timer_value;
		@(posedge clk);
		proto.sof <= 1'b0;
		proto.eof_last <= 1'b0;
		repeat (4) begin
			#1 if (cap_v === 1'b1) c++;
			if (cap_v === 1'b1)
				chk("capture val", t, cap_val);
			@(posedge clk);
		end
		chk("capture", 16'(exp), 16'(c));
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rchk("status", sa, STATUS_RESET);
		rchk("control", ca, CONTROL_RESET);
		rchk("unmapped", 8'h55, 8'h00);
		settle;
		chk("tx idle", 1, can_tx_pin);
		chk("timer off", 0, timer_value);
		wr(ca, 8'h02);
		@(posedge clk);
		#1 chk("clk en", 1, clk_en);
		chk("run early", 0, engine_run);
		@(posedge clk);
		#1 chk("run early", 0, engine_run);
		@(posedge clk);
		#1 chk("run", 1, engine_run);
		rchk("enabled", sa, 8'h04);
		chk("timer on", 1, timer_value !== 16'h0000);
		for (int i = 0; i < 8; i++) begin
			tec = (i == 1) ? 127 : (i == 2) ? 128 : $random(seed) & 255;
			rec = (i == 1) ? 127 : $random(seed) & 255;
			bo = (i % 3 == 0);
			@(posedge clk);
			proto.tec <= 8'(tec);
			proto.rec <= 8'(rec);
			proto.tec_bus_off <= 1'(bo);
			settle;
			rchk("err flags", sa, 8'(4 | (bo << 1) | (!bo && (tec > 127 || rec > 127))));
		end
		@(posedge clk);
		proto <= '0;
		wr(sa, 8'hFF);
		rchk("status ro", sa, 8'h04);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			proto.tx_frame <= (i == 0);
			proto.tx_pending <= (i == 1);
			proto.frame_idle <= (i == 1);
			proto.rx_frame <= (i == 2);
			settle;
			rchk("busy", sa, (i == 2) ? 8'h0C : 8'h14);
		end
		@(posedge clk);
		proto <= '0;
		proto.frame_idle <= 1'b1;
		wr(ca, 8'h2A);
		settle;
		chk("listen", 1, listen_only);
		chk("no retx", 1, no_retx);
		cap_cnt(0, 1);
		cap_cnt(1, 0);
		wr(ca, 8'h32);
		cap_cnt(1, 1);
		cap_cnt(0, 0);
		chk("listen", 0, listen_only);
		wr(ca, 8'h12);
		cap_cnt(1, 0);
		chk("no retx", 0, no_retx);
		wr(ca, 8'h42);
		settle;
		chk("ovl pend", 1, ovl_pend);
		@(posedge clk);
		proto.overload_start <= 1'b1;
		@(posedge clk);
		proto.overload_start <= 1'b0;
		ctl_m = ctl_m & 8'hBF;
		rchk("ovl clr", ca, 8'(ctl_m));
		rchk("ovl flag", sa, 8'h44);
		@(posedge clk);
		proto.overload_end <= 1'b1;
		@(posedge clk);
		proto.overload_end <= 1'b0;
		rchk("ovl flag", sa, 8'h04);
		set_obj;
		wr(ca, 8'h82);
		settle;
		chk("abort obj", 0, obj_en);
		chk("drop", 1, drop_tx);
		set_obj;
		repeat (20) @(posedge clk);
		rchk("abort kept", ca, 8'(ctl_m));
		chk("abort obj", 0, obj_en);
		wr(ca, 8'h02);
		set_obj;
		proto.tx_frame <= 1'b1;
		wr(ca, 8'h08);
		repeat (3) @(posedge clk);
		#1 chk("frame finish", 1, engine_run);
		@(posedge clk);
		proto.tx_frame <= 1'b0;
		n = 0;
		while (engine_run !== 1'b0 && n < 10) begin
			@(posedge clk);
			n++;
		end
		settle;
		chk("stopped", 0, engine_run);
		chk("obj kept", 16'h7FFF, obj_en);
		chk("tx recessive", 1, can_tx_pin);
		chk("clk gated", 0, clk_en);
		chk("rx idle", 1, rx_eng);
		rchk("ctl access", ca, 8'(ctl_m));
		rchk("standby", sa, 8'h00);
		wr(ca, 8'h0B);
		#1 chk("eng rst", 1, eng_rst);
		rchk("soft rst", ca, 8'(ctl_m));
		settle;
		chk("soft off", 0, engine_run);
		report_and_stop;
	end
endmodule
